// *** rtl/btr_core.sv ***
// barrel thread ring core: thread, pc and stack pointer rings around a six stage alu
`timescale 1ns/1ps
`default_nettype none
module btr_core #(
  parameter logic STK_PROT = 1'b1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // per thread clear and interrupt requests, asynchronous
  input wire logic [btr_pkg::THREADS-1:0] clr_req_i,
  input wire logic [btr_pkg::THREADS-1:0] irq_req_i,
  // decoded work and operands for the thread shown on tid_o
  input wire btr_pkg::btr_ctl_t ctl_i,
  input wire logic [btr_pkg::DATA_W-1:0] a_i,
  input wire logic [btr_pkg::DATA_W-1:0] b_i,
  // read or literal data for the thread in stage four
  input wire logic [btr_pkg::DATA_W-1:0] rd_data_i,
  // ring position and memory addresses
  output logic [btr_pkg::TID_W-1:0] tid_o,
  output logic [btr_pkg::ADDR_W-1:0] ins_addr_o,
  output logic [btr_pkg::ADDR_W-1:0] lit_addr_o,
  output logic lit_rd_o,
  // alu result and stack side
  output logic [btr_pkg::DATA_W-1:0] alu_res_o,
  output btr_pkg::btr_err_t stk_err_o,
  output wire logic [btr_pkg::STACKS-1:0][btr_pkg::DATA_W-1:0] stk_top_o
);
  localparam int DW = btr_pkg::DATA_W;
  localparam int AW = btr_pkg::ADDR_W;
  localparam int TW = btr_pkg::TID_W;
  localparam int NS = btr_pkg::STAGES;
  localparam int NT = btr_pkg::THREADS;
  localparam int NK = btr_pkg::STACKS;
  localparam int SW = btr_pkg::SP_W;
  localparam int OPW = btr_pkg::OP_W;

  typedef struct packed {
    logic [NT-1:0] clr_m;
    logic [NT-1:0] clr_s;
    logic [NT-1:0] clr_p;
    logic [NT-1:0] irq_m;
    logic [NT-1:0] irq_s;
    logic [NT-1:0] irq_p;
    logic [NT-1:0] clr_pend;
    logic [NT-1:0] irq_pend;
    logic [TW-1:0] cnt;
    btr_pkg::btr_stg_t [NS-1:0] stg;
    logic [DW-1:0] lo;
    logic [DW-1:0] hi;
    logic [DW-1:0] lg;
    logic [5:2][DW-1:0] d;
    logic [DW-1:0] res;
    logic [AW-1:0] ins;
    logic [AW-1:0] lit_addr;
    logic lit_rd;
    btr_pkg::btr_err_t err;
  } btr_core_st_t;

  btr_core_st_t st_q;
  btr_core_st_t st_d;

  // widen by one bit: sign copy when signed, zero when not
  function automatic logic [DW:0] btr_ext(input logic [DW-1:0] v, input logic sg);
    btr_ext = {sg & v[DW-1], v};
  endfunction

  function automatic logic [DW-1:0] btr_logic(input logic [OPW-1:0] op, input logic [DW-1:0] a,
                                              input logic [DW-1:0] b);
    btr_logic = ({DW{op[btr_pkg::OP_AND]}} & (a & b))
              | ({DW{op[btr_pkg::OP_OR]}} & (a | b))
              | ({DW{op[btr_pkg::OP_XOR]}} & (a ^ b))
              | ({DW{op[btr_pkg::OP_NOT]}} & ~b)
              | ({DW{op[btr_pkg::OP_ANDB]}} & {DW{&b}})
              | ({DW{op[btr_pkg::OP_ORB]}} & {DW{|b}})
              | ({DW{op[btr_pkg::OP_XORB]}} & {DW{^b}}); // see RULE4 see RULE5
  endfunction

  // address of a thread's stack slot in the shared memories
  function automatic logic [SW+TW-1:0] btr_slot(input logic [SW-1:0] sp, input logic [TW-1:0] tid);
    btr_slot = {sp, tid};
  endfunction

  assign tid_o = st_q.stg[0].tid;
  assign ins_addr_o = st_q.ins;
  assign lit_addr_o = st_q.lit_addr;
  assign lit_rd_o = st_q.lit_rd;
  assign alu_res_o = st_q.res;
  assign stk_err_o = st_q.err;

  always_comb begin
    logic [DW:0] ea;
    logic [DW:0] eb;
    logic [DW:0] sum;
    logic [NT-1:0] clr_rise;
    logic [NT-1:0] irq_rise;
    logic inj_clr;
    logic inj_irq;
    btr_pkg::btr_stg_t s;
    ea = '0;
    eb = '0;
    sum = '0;
    clr_rise = '0;
    irq_rise = '0;
    inj_clr = 1'b0;
    inj_irq = 1'b0;
    s = '0;
    st_d = st_q;

    // pin synchronisers; the second and third flops feed the edge detect
    st_d.clr_m = clr_req_i;
    st_d.clr_s = st_q.clr_m;
    st_d.clr_p = st_q.clr_s;
    st_d.irq_m = irq_req_i;
    st_d.irq_s = st_q.irq_m;
    st_d.irq_p = st_q.irq_s;
    clr_rise = st_q.clr_s & ~st_q.clr_p;
    irq_rise = st_q.irq_s & ~st_q.irq_p;

    // ring entry: counter hands out the next id, events land in that slot only
    st_d.cnt = st_q.cnt + btr_pkg::TID_STEP; // see RULE11
    inj_clr = st_q.clr_pend[st_q.cnt];
    inj_irq = st_q.irq_pend[st_q.cnt] & ~inj_clr; // see RULE18
    for (int t = 0; t < NT; t++) begin
      // a new request in the injection cycle survives: set beats clear
      st_d.clr_pend[t] = clr_rise[t] | (st_q.clr_pend[t] & ~(inj_clr && TW'(t) == st_q.cnt));
      st_d.irq_pend[t] = irq_rise[t] | (st_q.irq_pend[t] & ~(inj_irq && TW'(t) == st_q.cnt));
    end

    // default: every stage moves one place round the ring
    for (int k = 0; k < NS - 1; k++) begin
      st_d.stg[k+1] = st_q.stg[k]; // see RULE10
    end
    s = '0;
    s.tid = st_q.cnt;
    s.pc = st_q.stg[NS-1].pc;
    s.sp = st_q.stg[NS-1].sp;
    s.clr = inj_clr;
    s.irq = inj_irq;
    st_d.stg[0] = s;

    // stage 0: take decoded work, clear then interrupt override the decoder
    s = st_q.stg[0];
    s.ctl = ctl_i;
    s.boff = b_i[AW-1:0];
    s.we = '0;
    s.perr = '0;
    s.taken = 1'b0;
    if (s.clr) begin
      s.ctl = '0;
      s.pc = btr_pkg::CLR_BASE + AW'(s.tid); // see RULE13
    end else if (s.irq) begin
      // pc held so stage three can hand it out as the return address
      s.ctl = '0;
      s.ctl.sel_pc = 1'b1; // see RULE13
    end else begin
      s.pc = s.pc + btr_pkg::PC_STEP; // see RULE13
    end
    if (s.clr || s.ctl.stk_clr) begin
      s.sp = '0; // see RULE19
    end

    // alu entry: operands widened by their own signedness
    ea = btr_ext(a_i, s.ctl.sgn_a); // see RULE1
    eb = btr_ext(b_i, s.ctl.sgn_b); // see RULE1
    sum = s.ctl.sub ? ea - eb : ea + eb; // see RULE2
    st_d.lo = sum[DW-1:0]; // see RULE2
    st_d.hi = {DW{sum[DW]}}; // see RULE1
    st_d.lg = btr_logic(s.ctl.op, a_i, b_i);
    if (s.ctl.tst_ab) begin
      s.fz = ~|sum[DW-1:0]; // see RULE3
      s.fn = sum[DW]; // see RULE3
    end else begin
      s.fz = ~|a_i; // see RULE3
      s.fn = a_i[DW-1]; // see RULE3
    end
    st_d.stg[1] = s;

    // stage 1: literal address, branch test, pops
    s = st_q.stg[1];
    st_d.lit_rd = s.ctl.lit;
    if (s.ctl.lit) begin
      st_d.lit_addr = s.pc; // see RULE14
    end
    s.taken = ~s.ctl.br_cond
            | (s.ctl.tst[btr_pkg::TST_Z] & s.fz)
            | (s.ctl.tst[btr_pkg::TST_NZ] & ~s.fz)
            | (s.ctl.tst[btr_pkg::TST_LT] & s.fn)
            | (s.ctl.tst[btr_pkg::TST_GE] & ~s.fn);
    for (int k = 0; k < NK; k++) begin
      if (s.ctl.pop[k]) begin
        if (STK_PROT && s.sp[k] == btr_pkg::SP_EMPTY) begin
          s.perr[k] = 1'b1; // see RULE21
        end else begin
          s.sp[k] = s.sp[k] - btr_pkg::SP_STEP; // see RULE20
        end
      end
    end
    st_d.stg[2] = s;

    // alu stage 1 to 2: one-hot pick of the result, control taken from the pipe
    st_d.d[2] = ({DW{st_q.stg[1].ctl.op[btr_pkg::OP_ADD_LO]}} & st_q.lo)
              | ({DW{st_q.stg[1].ctl.op[btr_pkg::OP_ADD_HI]}} & st_q.hi)
              | st_q.lg; // see RULE9

    // stage 2: pc advance, pushes, stack error report
    s = st_q.stg[2];
    if (s.ctl.lit) begin
      s.pc = s.pc + btr_pkg::PC_STEP; // see RULE15
    end else if (s.ctl.jmp_rel && s.taken) begin
      s.pc = s.pc + (s.ctl.use_imm ? s.ctl.imm : s.boff); // see RULE15
    end
    st_d.err = '0;
    st_d.err.tid = s.tid;
    st_d.err.pop_err = s.perr;
    for (int k = 0; k < NK; k++) begin
      if (s.ctl.push[k]) begin
        if (STK_PROT && s.sp[k] == btr_pkg::SP_FULL) begin
          st_d.err.push_err[k] = 1'b1; // see RULE21
        end else begin
          s.sp[k] = s.sp[k] + btr_pkg::SP_STEP; // see RULE20
          s.we[k] = 1'b1; // see RULE22
        end
      end
    end
    st_d.err.valid = |{st_d.err.pop_err, st_d.err.push_err}; // see RULE21
    st_d.stg[3] = s;
    st_d.d[3] = st_q.d[2];

    // stage 3: pc into the alu, then interrupt or absolute jump target
    s = st_q.stg[3];
    st_d.d[4] = s.ctl.sel_pc ? {{(DW-AW){1'b0}}, s.pc} : st_q.d[3]; // see RULE7
    if (s.irq) begin
      s.pc = btr_pkg::IRQ_BASE + AW'(s.tid); // see RULE16
    end else if (s.ctl.jmp_abs && s.taken) begin
      s.pc = s.boff; // see RULE16
    end
    st_d.stg[4] = s;

    // stage 4: instruction fetch address, read data into the alu
    st_d.ins = st_q.stg[4].pc; // see RULE17
    st_d.d[5] = st_q.stg[4].ctl.sel_rd ? rd_data_i : st_q.d[4]; // see RULE8

    // stage 5 to 6: last alu register, result appears six clocks after entry
    st_d.res = st_q.d[5]; // see RULE6

    // synchronous reset: id pipe preloaded as if the counter had fed it
    if (rst_i) begin
      st_d = '0;
      st_d.cnt = btr_pkg::TID_RST;
      for (int k = 0; k < NS; k++) begin
        st_d.stg[k].tid = btr_pkg::TID_RST - TW'(k + 1); // see RULE12
      end
    end
  end

  always_ff @(posedge clock_i) begin
    st_q <= st_d;
  end

  // one memory per stack keeps stacks of a thread apart; the thread id keeps threads apart
  for (genvar k = 0; k < NK; k++) begin : g_stk
    btr_lifo_ram #(
      .DW(DW),
      .AW(SW + TW)
    ) u_ram (
      .clock_i(clock_i),
      .wr_en_i(st_q.stg[6].we[k]),
      .wr_addr_i(btr_slot(st_q.stg[6].sp[k], st_q.stg[6].tid)),
      .wr_data_i(st_q.res),
      .rd_addr_i(btr_slot(st_q.stg[NS-1].sp[k], st_q.stg[NS-1].tid)),
      .rd_data_o(stk_top_o[k])
    ); // see RULE22
  end
endmodule
`default_nettype wire

// *** shared/btr_pkg.sv ***
// constants and carrier types for the barrel thread ring core
// Notes on behaviour
// RULE1 - adder widens each operand one bit by its own signedness; upper word holds carry
// RULE2 - lower sum word is the same for signed and unsigned; only upper word differs
// RULE3 - a against b tests use the adder; a against zero tests look at a directly
// RULE4 - logic unit gives a and b, a or b, a xor b, and not b
// RULE5 - logic unit gives and, or, xor reductions of b spread over every bit
// RULE6 - alu takes new work every clock and answers six clocks after entry
// RULE7 - program counter can enter the alu between its third and fourth stages
// RULE8 - read or literal data can enter the alu between its fourth and fifth stages
// RULE9 - one-hot alu controls travel in pipeline registers beside their data
// RULE10 - eight stage closed ring, one thread per stage, one stage per clock
// RULE11 - thread ids come from an entry counter feeding a pipe, each once per eight clocks
// RULE12 - reset loads the id pipe as if already fed, so thread zero emerges first
// RULE13 - stage zero: pc gets clear address, holds on interrupt, else increments
// RULE14 - stage one: pc addresses the data port when fetching an in-line literal
// RULE15 - stage two: pc plus one for literal, plus offset on taken relative jump
// RULE16 - stage three: pc gets interrupt address, or b on taken absolute jump
// RULE17 - stage four: pc addresses the instruction port for the next fetch
// RULE18 - per thread clear and interrupt injected at its own slot, clear first
// RULE19 - stage zero: stack pointers cleared on thread clear or stack clear
// RULE20 - pops decrement in stage one, then a push increments in stage two
// RULE21 - optional guard blocks full pushes and empty pops and reports them
// RULE22 - push enables reach stage six; result written at pointer and thread id
package btr_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int THREADS = 8;
  localparam int TID_W = 3;
  localparam int STAGES = 8;
  localparam int STACKS = 4;
  localparam int SP_W = 5;
  localparam logic [ADDR_W-1:0] CLR_BASE = 16'h0000;
  localparam logic [ADDR_W-1:0] IRQ_BASE = 16'h0020;
  localparam logic [ADDR_W-1:0] PC_STEP = 16'h0001;
  localparam logic [TID_W-1:0] TID_STEP = 3'h1;
  localparam logic [TID_W-1:0] TID_RST = 3'h0;
  localparam logic [SP_W-1:0] SP_STEP = 5'h01;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
  localparam logic [SP_W-1:0] SP_FULL = 5'h1f;
  // one-hot alu operation bit positions
  localparam int OP_ADD_LO = 0;
  localparam int OP_ADD_HI = 1;
  localparam int OP_AND = 2;
  localparam int OP_OR = 3;
  localparam int OP_XOR = 4;
  localparam int OP_NOT = 5;
  localparam int OP_ANDB = 6;
  localparam int OP_ORB = 7;
  localparam int OP_XORB = 8;
  localparam int OP_W = 9;
  // one-hot branch test bit positions
  localparam int TST_Z = 0;
  localparam int TST_NZ = 1;
  localparam int TST_LT = 2;
  localparam int TST_GE = 3;
  localparam int TST_W = 4;

  typedef struct packed {
    logic [OP_W-1:0] op;
    logic sub;
    logic sgn_a;
    logic sgn_b;
    logic tst_ab;
    logic [TST_W-1:0] tst;
    logic br_cond;
    logic jmp_rel;
    logic jmp_abs;
    logic use_imm;
    logic [ADDR_W-1:0] imm;
    logic lit;
    logic sel_pc;
    logic sel_rd;
    logic stk_clr;
    logic [STACKS-1:0] pop;
    logic [STACKS-1:0] push;
  } btr_ctl_t;

  typedef struct packed {
    logic [TID_W-1:0] tid;
    logic [ADDR_W-1:0] pc;
    logic [STACKS-1:0][SP_W-1:0] sp;
    logic clr;
    logic irq;
    btr_ctl_t ctl;
    logic [ADDR_W-1:0] boff;
    logic fz;
    logic fn;
    logic taken;
    logic [STACKS-1:0] perr;
    logic [STACKS-1:0] we;
  } btr_stg_t;

  typedef struct packed {
    logic valid;
    logic [TID_W-1:0] tid;
    logic [STACKS-1:0] pop_err;
    logic [STACKS-1:0] push_err;
  } btr_err_t;
endpackage

// *** rtl/btr_lifo_ram.sv ***
// one stack memory: registered read, single write port
`timescale 1ns/1ps
`default_nettype none
module btr_lifo_ram #(
  parameter int DW = 32,
  parameter int AW = 8
) (
  // clock
  input wire logic clock_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // read side
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule
`default_nettype wire

// *** verification/btr_core_assertions.sv ***
// port assertions for the barrel thread ring core
`timescale 1ns/1ps
`default_nettype none
module btr_core_assertions (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // entry side
  input wire btr_pkg::btr_ctl_t ctl_i,
  input wire logic [btr_pkg::DATA_W-1:0] a_i,
  input wire logic [btr_pkg::DATA_W-1:0] b_i,
  // observed outputs
  input wire logic [btr_pkg::TID_W-1:0] tid_o,
  input wire logic lit_rd_o,
  input wire logic [btr_pkg::DATA_W-1:0] alu_res_o,
  input wire btr_pkg::btr_err_t stk_err_o
);
  logic [btr_pkg::DATA_W:0] ea;
  logic [btr_pkg::DATA_W:0] eb;
  logic [btr_pkg::DATA_W:0] wide_sum;
  assign ea = {ctl_i.sgn_a & a_i[btr_pkg::DATA_W-1], a_i};
  assign eb = {ctl_i.sgn_b & b_i[btr_pkg::DATA_W-1], b_i};
  assign wide_sum = ctl_i.sub ? ea - eb : ea + eb;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_TID_STEP: assert property (!$past(rst_i) |-> tid_o == $past(tid_o) + btr_pkg::TID_STEP)
    else $error("thread id did not step by one");
  AST_TID_RST: assert property ($fell(rst_i) |=> tid_o == btr_pkg::TID_RST)
    else $error("thread zero not first after reset");
  AST_LIT: assert property (lit_rd_o |-> $past(ctl_i.lit, 2))
    else $error("literal fetch without literal request");
  AST_ADD_LO: assert property ($past(ctl_i.op[btr_pkg::OP_ADD_LO], 6) |-> alu_res_o == $past(wide_sum[31:0], 6))
    else $error("lower sum wrong");
  AST_ADD_HI: assert property ($past(ctl_i.op[btr_pkg::OP_ADD_HI], 6) |-> alu_res_o == {32{$past(wide_sum[32], 6)}})
    else $error("upper sum word wrong");
  AST_NOT: assert property ($past(ctl_i.op[btr_pkg::OP_NOT], 6) |-> alu_res_o == ~$past(b_i, 6))
    else $error("inversion of b wrong");
  AST_ORB: assert property ($past(ctl_i.op[btr_pkg::OP_ORB], 6) |-> alu_res_o == {32{$past(|b_i, 6)}})
    else $error("or reduction wrong");
  AST_ERR_POP: assert property (stk_err_o.valid |-> (stk_err_o.pop_err & ~$past(ctl_i.pop, 3)) == 4'h0)
    else $error("pop error without pop");
  AST_ERR_TID: assert property (stk_err_o.valid |-> stk_err_o.tid == $past(tid_o, 3))
    else $error("stack error carries wrong thread");
endmodule
bind btr_core btr_core_assertions i_btr_core_assertions (.clock_i(clock_i), .rst_i(rst_i), .ctl_i(ctl_i),
  .a_i(a_i), .b_i(b_i), .tid_o(tid_o), .lit_rd_o(lit_rd_o), .alu_res_o(alu_res_o), .stk_err_o(stk_err_o));
`default_nettype wire

// *** verification/btr_mem_model.sv ***
// main memory data port model answering literal fetches
`timescale 1ns/1ps
`default_nettype none
module btr_mem_model #(
  parameter logic [15:0] TAG = 16'hc3c3
) (
  // clock
  input wire logic clock_i,
  // request from the core
  input wire logic lit_rd_i,
  input wire logic [btr_pkg::ADDR_W-1:0] addr_i,
  // answer
  output logic [btr_pkg::DATA_W-1:0] rd_data_o
);
  logic pend_q = 1'b0;
  logic [btr_pkg::ADDR_W-1:0] addr_q = '0;
  initial rd_data_o = 32'h0;
  // data must stand while the thread sits in stage four, two clocks after the request
  // outside an answer the port toggles so stale data never looks right
  always @(posedge clock_i) begin
    pend_q <= lit_rd_i;
    addr_q <= addr_i;
    rd_data_o <= pend_q ? {TAG, addr_q} : ~rd_data_o;
  end
endmodule
`default_nettype wire

// *** verification/test_barrel_thread_ring_core.sv ***
// self-checking bench for the barrel thread ring core
`timescale 1ns/1ps
`default_nettype none
module test_barrel_thread_ring_core;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] clr_req_i = 8'h00;
  logic [7:0] irq_req_i = 8'h00;
  btr_pkg::btr_ctl_t ctl_i = '0;
  logic [31:0] a_i = 32'h0;
  logic [31:0] b_i = 32'h0;
  logic [31:0] rd_data;
  logic [31:0] alu_res_o;
  logic [2:0] tid_o;
  logic [15:0] ins_addr_o;
  logic [15:0] lit_addr_o;
  logic lit_rd_o;
  btr_pkg::btr_err_t stk_err_o;
  logic [3:0][31:0] stk_top_o;
  logic [32:0] cur = 33'h0;
  logic [32:0] ep [6];
  logic [15:0] hist [$];
  logic log_on = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  btr_pkg::btr_ctl_t c;
  btr_pkg::btr_err_t e;
  logic f;
  btr_core i_btr_core (.clock_i(clock_i), .rst_i(rst_i), .clr_req_i(clr_req_i), .irq_req_i(irq_req_i),
    .ctl_i(ctl_i), .a_i(a_i), .b_i(b_i), .rd_data_i(rd_data), .tid_o(tid_o), .ins_addr_o(ins_addr_o),
    .lit_addr_o(lit_addr_o), .lit_rd_o(lit_rd_o), .alu_res_o(alu_res_o), .stk_err_o(stk_err_o),
    .stk_top_o(stk_top_o));
  btr_mem_model i_btr_mem_model (.clock_i(clock_i), .lit_rd_i(lit_rd_o), .addr_i(lit_addr_o), .rd_data_o(rd_data));
  always #2.5 clock_i = ~clock_i;
  // expected results ride a six deep pipe beside the design
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    ep[0] <= cur;
    for (int i = 1; i < 6; i++) begin
      ep[i] <= ep[i-1];
    end
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  always @(negedge clock_i) begin
    if (log_on) begin
      hist.push_back(ins_addr_o);
      if (lit_rd_o) begin
        hist.push_back(lit_addr_o | 16'h8000);
      end
    end
    if (ep[5][32] === 1'b1) chk(alu_res_o, ep[5][31:0], "alu result");
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task found(input logic [15:0] v, output logic r);
    r = 1'b0;
    foreach (hist[i]) if (hist[i] === v) r = 1'b1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [31:0] ref_alu(int k, logic s, logic sa, logic sb, logic [31:0] a, logic [31:0] b);
    logic [32:0] w;
    w = s ? {sa & a[31], a} - {sb & b[31], b} : {sa & a[31], a} + {sb & b[31], b};
    case (k)
      btr_pkg::OP_ADD_LO: ref_alu = w[31:0];
      btr_pkg::OP_ADD_HI: ref_alu = {32{w[32]}};
      btr_pkg::OP_AND: ref_alu = a & b;
      btr_pkg::OP_OR: ref_alu = a | b;
      btr_pkg::OP_XOR: ref_alu = a ^ b;
      btr_pkg::OP_NOT: ref_alu = ~b;
      btr_pkg::OP_ANDB: ref_alu = {32{&b}};
      btr_pkg::OP_ORB: ref_alu = {32{|b}};
      default: ref_alu = {32{^b}};
    endcase
  endfunction
  task put(input btr_pkg::btr_ctl_t k, input logic [31:0] a, input logic [31:0] b, input logic [32:0] x);
    @(posedge clock_i);
    ctl_i <= k;
    a_i <= a;
    b_i <= b;
    cur <= x;
  endtask
  task on_tid(input logic [2:0] t);
    @(negedge clock_i);
    for (int i = 0; i < 16 && tid_o !== t - 3'h1; i++) @(negedge clock_i);
  endtask
  task issue(input logic [2:0] t, input btr_pkg::btr_ctl_t k, input logic [31:0] a, input logic [31:0] b,
             input logic [32:0] x);
    on_tid(t);
    put(k, a, b, x);
    put('0, 32'h0, 32'h0, 33'h0);
  endtask
  task t_tid;
    // the release edge itself still sees reset, so thread zero shows one edge later
    @(posedge clock_i);
    for (int i = 0; i < 16; i++) begin
      @(negedge clock_i);
      chk(tid_o, i % 8, "thread id order");
    end
  endtask
  task t_jmp;
    c = '0;
    c.jmp_abs = 1'b1;
    for (int i = 0; i < 8; i++) put(c, 32'h0, 32'h400, 33'h0);
    put('0, 32'h0, 32'h0, 33'h0);
    hist.delete();
    log_on = 1'b1;
    repeat (16) @(negedge clock_i);
    found(16'h0400, f);
    chk(f, 1, "absolute jump fetch");
  endtask
  task t_alu;
    logic [31:0] bb;
    for (int p = 0; p < 3; p++) begin
      bb = p == 0 ? 32'hffffffff : (p == 1 ? 32'h0 : 32'h80000005);
      for (int m = 0; m < 8; m++) begin
        for (int k = 0; k < 9; k++) begin
          c = '0;
          c.op[k] = 1'b1;
          c.sub = m[2];
          c.sgn_a = m[0];
          c.sgn_b = m[1];
          put(c, 32'hfffffff0 + m, bb, {1'b1, ref_alu(k, m[2], m[0], m[1], 32'hfffffff0 + m, bb)});
        end
      end
    end
    put('0, 32'h0, 32'h0, 33'h0);
    repeat (8) @(negedge clock_i);
  endtask
  task t_br;
    hist.delete();
    c = '0;
    c.jmp_abs = 1'b1;
    issue(2, c, 32'h0, 32'h100, 33'h0);
    c = '0;
    c.jmp_rel = 1'b1;
    c.br_cond = 1'b1;
    c.tst_ab = 1'b1;
    c.sub = 1'b1;
    c.tst[btr_pkg::TST_Z] = 1'b1;
    c.use_imm = 1'b1;
    c.imm = 16'h0010;
    issue(2, c, 32'h7, 32'h7, 33'h0);
    c = '0;
    c.lit = 1'b1;
    c.sel_rd = 1'b1;
    issue(2, c, 32'h0, 32'h0, {1'b1, 32'hc3c30112});
    c = '0;
    c.sel_pc = 1'b1;
    issue(2, c, 32'h0, 32'h0, {1'b1, 32'h00000114});
    repeat (24) @(negedge clock_i);
    found(16'h0111, f);
    chk(f, 1, "relative jump on equal");
    found(16'h8112, f);
    chk(f, 1, "literal fetch address");
    found(16'h0113, f);
    chk(f, 1, "step past literal");
  endtask
  task t_stk;
    c = '0;
    c.op[btr_pkg::OP_ADD_LO] = 1'b1;
    c.push[0] = 1'b1;
    issue(1, c, 32'h5, 32'h0, {1'b1, 32'h5});
    repeat (16) @(negedge clock_i);
    on_tid(2);
    chk(stk_top_o[0], 32'h5, "stack top after push");
    c = '0;
    c.pop = 4'h3;
    issue(1, c, 32'h0, 32'h0, 33'h0);
    e = '0;
    repeat (8) @(negedge clock_i) if (stk_err_o.valid === 1'b1) e = stk_err_o;
    chk(e.pop_err, 4'h2, "empty pop flagged");
    chk(e.tid, 1, "error thread");
    c = '0;
    c.push[0] = 1'b1;
    issue(1, c, 32'h0, 32'h0, 33'h0);
    c = '0;
    c.stk_clr = 1'b1;
    c.pop = 4'h1;
    issue(1, c, 32'h0, 32'h0, 33'h0);
    e = '0;
    repeat (8) @(negedge clock_i) if (stk_err_o.valid === 1'b1) e = stk_err_o;
    chk(e.pop_err, 4'h1, "stack clear empties pointer");
    // 31 usable slots: the next push must be refused
    c = '0;
    c.push[3] = 1'b1;
    for (int i = 0; i < 31; i++) issue(6, c, 32'h0, 32'h0, 33'h0);
    e = '0;
    issue(6, c, 32'h0, 32'h0, 33'h0);
    repeat (8) @(negedge clock_i) if (stk_err_o.valid === 1'b1) e = stk_err_o;
    chk(e.push_err, 4'h8, "full push flagged");
    chk(e.tid, 6, "full push thread");
  endtask
  task t_evt;
    hist.delete();
    @(posedge clock_i) clr_req_i <= 8'h08;
    repeat (48) @(negedge clock_i);
    found(16'h0003, f);
    chk(f, 1, "clear address fetched");
    found(16'h0002, f);
    chk(f, 0, "other thread disturbed");
    hist.delete();
    @(posedge clock_i) irq_req_i <= 8'h20;
    repeat (48) @(negedge clock_i);
    found(16'h0025, f);
    chk(f, 1, "interrupt address fetched");
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    t_tid();
    t_jmp();
    t_alu();
    t_br();
    t_stk();
    t_evt();
    results();
  end
endmodule
`default_nettype wire
